/* File: inc/ssp_pkg.sv */
package ssp_pkg;

	// Select mode field encodings.
	localparam logic [1:0] SSP_MODE_3WIRE = 2'h0;
	localparam logic [1:0] SSP_MODE_4W_SLAVE = 2'h1;
	localparam int SSP_MODE_OUT_BIT = 1;
	localparam int SSP_MODE_LEVEL_BIT = 0;

	// Serial clock timing for master operation.
	localparam int SSP_CLK_PERIOD_NS = 5;
	localparam int SSP_SCK_HALF_NS = 40;
	localparam int SSP_SCK_HALF_CYC_I = (SSP_SCK_HALF_NS + SSP_CLK_PERIOD_NS - 1)
		/ SSP_CLK_PERIOD_NS;
	localparam logic [7:0] SSP_SCK_HALF_CYC = 8'(SSP_SCK_HALF_CYC_I);
	localparam logic [7:0] SSP_DIV_ONE = 8'h01;

	localparam logic [2:0] SSP_LAST_BIT = 3'h7;
	localparam logic [2:0] SSP_BIT_ONE = 3'h1;
	localparam logic [7:0] SSP_BYTE_ZERO = 8'h00;

	typedef enum logic [0:0] {
		SSP_IDLE = 1'b0,
		SSP_RUN = 1'b1
	} ssp_mstate_t;

	// Configuration written by software in one strobe.
	typedef struct packed {
		logic [1:0] select_mode_field;
		logic master_enable_bit;
		logic port_enable_bit;
	} ssp_cfg_t;

	// Pin drive levels and output enables.
	typedef struct packed {
		logic mosi;
		logic mosi_oe;
		logic miso_oe;
		logic sck;
		logic sck_oe;
		logic nss;
		logic nss_oe;
		logic nss_mapped;
	} ssp_pins_t;

	// State on the system clock.
	typedef struct packed {
		ssp_cfg_t cfg;
		logic mode_fault_flag;
		logic transfer_done_flag;
		logic overrun_flag;
		logic collision_flag;
		logic [7:0] rx_data;
		logic [7:0] tx_buf;
		logic [7:0] sh;
		logic [2:0] cnt;
		logic [7:0] div;
		ssp_mstate_t mstate;
		ssp_pins_t pins;
		logic hold;
		logic nss_prev;
		logic tgl_prev;
		logic link_rst;
	} ssp_sys_t;

	// Link logic on the leading serial clock edge: drives the slave output.
	typedef struct packed {
		logic [7:0] tx_sh;
		logic [2:0] cnt;
		logic miso;
	} ssp_lead_t;

	// Link logic on the trailing serial clock edge: captures slave input.
	typedef struct packed {
		logic [7:0] rx_sh;
		logic [2:0] cnt;
	} ssp_trail_t;

	// Completed slave byte and its toggle: kept across select changes.
	typedef struct packed {
		logic [7:0] rx_byte;
		logic tgl;
	} ssp_cap_t;

endpackage : ssp_pkg

/* File: testbench/spi_signal_select_modes_test.sv */
`timescale 1ns/100ps

module spi_signal_select_modes_test;
	logic i_clk;
	logic i_reset;
	logic cfg_write;
	ssp_pkg::ssp_cfg_t cfg;
	ssp_pkg::ssp_cfg_t o_cfg;
	ssp_pkg::ssp_pins_t pins;
	logic tx_write;
	logic [7:0] tx_data;
	logic done_clr, fault_clr, ovr_clr, col_clr;
	logic sck_link, mosi, miso, nss, o_miso, busy, done, fault, ovr, col;
	logic [7:0] rx;
	logic [7:0] got;
	logic [7:0] flg;
	int err_total;
	int cmp_count;

	assign flg = {busy, done, fault, ovr, col, pins.miso_oe, pins.nss_oe, pins.nss_mapped};
	ssp_port ssp_port_inst (.i_clk, .i_reset, .i_sck_link(sck_link), .i_cfg_write(cfg_write),
		.i_cfg(cfg), .i_tx_write(tx_write), .i_tx_data(tx_data), .i_done_clear(done_clr),
		.i_fault_clear(fault_clr), .i_overrun_clear(ovr_clr), .i_collision_clear(col_clr),
		.i_mosi(mosi), .i_miso(miso), .i_nss(nss), .o_cfg, .o_transfer_done_flag(done),
		.o_mode_fault_flag(fault), .o_overrun_flag(ovr), .o_collision_flag(col),
		.o_busy(busy), .o_rx_data(rx), .o_pins(pins), .o_miso);
	ssp_far_end ssp_far_end_inst (.i_sck(pins.sck), .i_mosi(pins.mosi), .i_miso(o_miso),
		.o_sck_link(sck_link), .o_mosi(mosi), .o_miso(miso), .o_nss(nss));

	initial begin
		i_clk = 1'h0;
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc
	task automatic set_cfg(input logic [3:0] c);
		cfg = c;
		cfg_write = 1'h1;
		cyc(1);
		cfg_write = 1'h0;
		cyc(2);
	endtask : set_cfg
	task automatic clear_all();
		done_clr = 1'h1;
		fault_clr = 1'h1;
		ovr_clr = 1'h1;
		col_clr = 1'h1;
		cyc(1);
		done_clr = 1'h0;
		fault_clr = 1'h0;
		ovr_clr = 1'h0;
		col_clr = 1'h0;
	endtask : clear_all
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask : pulse
	task automatic send(input logic [7:0] b);
		tx_data = b;
		tx_write = 1'h1;
		cyc(1);
		tx_write = 1'h0;
	endtask : send
	task automatic wait_lvl(ref logic s, input logic lvl);
		int n;
		n = 0;
		while (s !== lvl && n < 400) begin
			cyc(1);
			n++;
		end
		if (s !== lvl) begin
			err_total++;
			$display("CHECK FAILED wait expected %h seen %h", lvl, s);
			finish_test();
		end
	endtask : wait_lvl
	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	initial begin
		i_reset = 1'h1;
		cfg_write = 1'h0;
		cfg = 4'h0;
		tx_write = 1'h0;
		tx_data = 8'h00;
		done_clr = 1'h0;
		fault_clr = 1'h0;
		ovr_clr = 1'h0;
		col_clr = 1'h0;
		err_total = 0;
		cmp_count = 0;
		// The synchroniser resets to the idle line levels, so two edges suffice.
		cyc(2);
		i_reset = 1'h0;
		check("reset cfg", {4'h0, o_cfg}, 8'h04);
		check("reset flags", flg, 8'h01);
		// Select output modes are only exercised with the master enabled.
		for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
			set_cfg({m[1:0], 2'h3});
			check("master pins", {1'h0, pins[6:3], pins.nss & m[1], pins[1:0]},
				{5'h09, m[1] & m[0], m[1], m != 3'h0});
		end
		$display("test modes done");
		set_cfg(4'h3);
		clear_all();
		ssp_far_end_inst.slv_sh = 8'ha5;
		tx_data = 8'h3c;
		tx_write = 1'h1;
		cyc(1);
		tx_data = 8'hff;
		cyc(1);
		tx_write = 1'h0;
		wait_lvl(busy, 1'h0);
		check("master rx", rx, 8'ha5);
		check("master tx", ssp_far_end_inst.slv_got, 8'h3c);
		check("master flags", flg, 8'h48);
		pulse(col_clr);
		check("collision clear", flg, 8'h40);
		$display("test master done");
		set_cfg(4'h7);
		clear_all();
		send(8'h00);
		cyc(20);
		ssp_far_end_inst.sel(1'h0);
		cyc(8);
		check("fault cfg", {4'h0, o_cfg}, 8'h04);
		check("fault flags", flg, 8'h21);
		pulse(fault_clr);
		check("fault clear", flg, 8'h01);
		$display("test fault done");
		ssp_far_end_inst.sel(1'h1);
		set_cfg(4'h5);
		clear_all();
		cyc(4);
		check("unselected", flg, 8'h01);
		ssp_far_end_inst.xfer(8'hff, 8, got);
		cyc(10);
		check("ignored clock", flg, 8'h01);
		send(8'h5a);
		ssp_far_end_inst.sel(1'h0);
		cyc(4);
		check("selected", flg, 8'h05);
		ssp_far_end_inst.xfer(8'h00, 3, got);
		ssp_far_end_inst.sel(1'h1);
		cyc(4);
		ssp_far_end_inst.sel(1'h0);
		cyc(4);
		ssp_far_end_inst.xfer(8'hc3, 8, got);
		wait_lvl(done, 1'h1);
		check("slave rx", rx, 8'hc3);
		check("slave tx", got, 8'h5a);
		ssp_far_end_inst.xfer(8'h11, 8, got);
		cyc(10);
		check("overrun flags", flg, 8'h55);
		check("overrun rx", rx, 8'hc3);
		pulse(ovr_clr);
		check("overrun clear", flg, 8'h45);
		pulse(done_clr);
		check("done clear", flg, 8'h05);
		$display("test slave4 done");
		ssp_far_end_inst.sel(1'h1);
		set_cfg(4'h1);
		clear_all();
		cyc(4);
		check("three wire", flg, 8'h04);
		ssp_far_end_inst.xfer(8'h96, 8, got);
		wait_lvl(done, 1'h1);
		check("three wire rx", rx, 8'h96);
		check("three wire tx", got, 8'h5a);
		clear_all();
		set_cfg(4'h0);
		check("disabled", flg, 8'h00);
		$display("test slave3 done");
		finish_test();
	end
endmodule : spi_signal_select_modes_test

/* File: testbench/ssp_far_end.sv */
`timescale 1ns/100ps

// Sole master and sole slave on the lines, so no other device contends.
module ssp_far_end (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_miso,
	output logic o_sck_link,
	output logic o_mosi,
	output logic o_miso,
	output logic o_nss
);
	logic [7:0] slv_sh;
	logic [7:0] slv_got;
	initial begin
		o_sck_link = 1'h0;
		o_mosi = 1'h0;
		o_nss = 1'h1;
		slv_sh = 8'h00;
		slv_got = 8'h00;
	end
	assign o_miso = slv_sh[7];
	always @(negedge i_sck) begin
		slv_got = {slv_got[6:0], i_mosi};
		slv_sh = {slv_sh[6:0], ~slv_sh[0]};
	end
	task automatic sel(input logic v);
		o_nss = v;
	endtask : sel
	// The link clock runs only inside xfer, whatever the select level; mosi shows the inverse of its last bit once released.
	task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] got);
		got = 8'h00;
		for (int i = 0; i < n; i++) begin
			o_mosi = b[7 - i];
			#8 o_sck_link = 1'h1;
			#16 got = {got[6:0], i_miso};
			o_sck_link = 1'h0;
			#8;
		end
		o_mosi = ~o_mosi;
	endtask : xfer
endmodule : ssp_far_end

/* File: testbench/ssp_port_monitor.sv */
`timescale 1ns/100ps

module ssp_port_monitor (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_nss,
	input wire logic [7:0] i_tx_data,
	input wire ssp_pkg::ssp_cfg_t o_cfg,
	input wire logic o_busy,
	input wire logic o_mode_fault_flag,
	input wire ssp_pkg::ssp_pins_t o_pins
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	property p_mosi_msb;
		$rose(o_busy) |-> o_pins.mosi == $past(i_tx_data[7]);
	endproperty
	a_mosi_msb: assert property (p_mosi_msb) else $error("mosi is not the byte msb");
	property p_sck;
		$rose(o_busy) |-> !o_pins.sck [*8] ##1 o_pins.sck;
	endproperty
	a_sck: assert property (p_sck) else $error("serial clock timing wrong");
	property p_oe;
		(o_pins.mosi_oe == (o_cfg.master_enable_bit && o_cfg.port_enable_bit))
			&& (o_pins.sck_oe == o_pins.mosi_oe);
	endproperty
	a_oe: assert property (p_oe) else $error("master pin enables wrong");
	property p_nss_out;
		o_cfg.select_mode_field[1] |=> o_pins.nss_oe && o_pins.nss == $past(o_cfg[2]);
	endproperty
	a_nss_out: assert property (p_nss_out) else $error("select output wrong");
	property p_map;
		o_pins.nss_mapped == ($past(o_cfg.select_mode_field) != 2'h0);
	endproperty
	a_map: assert property (p_map) else $error("select pin mapping wrong");
	property p_miso_off;
		!o_cfg.port_enable_bit |=> !o_pins.miso_oe;
	endproperty
	a_miso_off: assert property (p_miso_off) else $error("miso driven while off");
	property p_unsel;
		(o_cfg == 4'h5 && i_nss) [*4] |=> !o_pins.miso_oe;
	endproperty
	a_unsel: assert property (p_unsel) else $error("miso driven unselected");
	property p_fault;
		(o_cfg == 4'h7 && $fell(i_nss)) |-> ##[1:4] (o_mode_fault_flag && o_cfg == 4'h4);
	endproperty
	a_fault: assert property (p_fault) else $error("master not disabled");
endmodule : ssp_port_monitor

bind ssp_port ssp_port_monitor ssp_port_monitor_inst (.i_clk, .i_reset, .i_nss, .i_tx_data,
	.o_cfg, .o_busy, .o_mode_fault_flag, .o_pins);

/* File: verilog/ssp_port.sv */
`timescale 1ns/100ps

module ssp_port (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_sck_link,
	input wire logic i_cfg_write,
	input wire ssp_pkg::ssp_cfg_t i_cfg,
	input wire logic i_tx_write,
	input wire logic [7:0] i_tx_data,
	input wire logic i_done_clear,
	input wire logic i_fault_clear,
	input wire logic i_overrun_clear,
	input wire logic i_collision_clear,
	input wire logic i_mosi,
	input wire logic i_miso,
	input wire logic i_nss,
	output ssp_pkg::ssp_cfg_t o_cfg,
	output logic o_transfer_done_flag,
	output logic o_mode_fault_flag,
	output logic o_overrun_flag,
	output logic o_collision_flag,
	output logic o_busy,
	output logic [7:0] o_rx_data,
	output ssp_pkg::ssp_pins_t o_pins,
	output logic o_miso
);

	ssp_pkg::ssp_sys_t sys_r;
	ssp_pkg::ssp_sys_t sys_nxt;
	ssp_pkg::ssp_lead_t lead_r;
	ssp_pkg::ssp_lead_t lead_nxt;
	ssp_pkg::ssp_trail_t trail_r;
	ssp_pkg::ssp_trail_t trail_nxt;
	ssp_pkg::ssp_cap_t cap_r;
	ssp_pkg::ssp_cap_t cap_nxt;

	logic nss_s;
	logic miso_s;
	logic tgl_s;

	// The select line, the master-in pin and the byte toggle from the link
	// logic all come from outside the system clock domain.
	// The select line idles high, so its stages reset high and no false fall is seen.
	ssp_sync #(
		.W(3),
		.RST_VAL(3'h4)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_nss, i_miso, cap_r.tgl}),
		.o_sync({nss_s, miso_s, tgl_s})
	);

	logic three_wire;
	logic four_slave_in;
	logic select_out;
	logic is_master;
	logic is_slave;
	logic selected;
	logic nss_fall;
	logic slave_byte;
	logic master_byte;
	logic tx_accept;
	logic sck_tick;

	always_comb begin
		three_wire = (sys_r.cfg.select_mode_field == ssp_pkg::SSP_MODE_3WIRE);
		four_slave_in = (sys_r.cfg.select_mode_field == ssp_pkg::SSP_MODE_4W_SLAVE);
		select_out = sys_r.cfg.select_mode_field[ssp_pkg::SSP_MODE_OUT_BIT];
		is_master = sys_r.cfg.port_enable_bit && sys_r.cfg.master_enable_bit;
		is_slave = sys_r.cfg.port_enable_bit && !sys_r.cfg.master_enable_bit;
		// A 3-wire slave has no select line, so it always counts as selected.
		selected = three_wire || (four_slave_in && !nss_s);
		nss_fall = sys_r.nss_prev && !nss_s;
		slave_byte = (tgl_s != sys_r.tgl_prev) && is_slave;
		sck_tick = (sys_r.div == ssp_pkg::SSP_DIV_ONE);
		master_byte = (sys_r.mstate == ssp_pkg::SSP_RUN) && sck_tick && sys_r.pins.sck
			&& (sys_r.cnt == ssp_pkg::SSP_LAST_BIT);
		tx_accept = i_tx_write && (sys_r.mstate == ssp_pkg::SSP_IDLE);
	end

	always_comb begin
		sys_nxt = sys_r;
		sys_nxt.nss_prev = nss_s;
		sys_nxt.tgl_prev = tgl_s;
		sys_nxt.link_rst = 1'b0;

		if (i_cfg_write) begin
			sys_nxt.cfg = i_cfg;
		end

		// Flags: a hardware set in the same cycle as a clear wins.
		if (i_done_clear) begin
			sys_nxt.transfer_done_flag = 1'b0;
		end
		if (i_fault_clear) begin
			sys_nxt.mode_fault_flag = 1'b0;
		end
		if (i_overrun_clear) begin
			sys_nxt.overrun_flag = 1'b0;
		end
		if (i_collision_clear) begin
			sys_nxt.collision_flag = 1'b0;
		end

		// The transmit buffer is loaded only while no master byte is running.
		// The slave link side reads it at each byte start, so software should
		// refill it before the master begins the next byte.
		if (i_tx_write) begin
			if (tx_accept) begin
				sys_nxt.tx_buf = i_tx_data;
			end else begin
				sys_nxt.collision_flag = 1'b1;
			end
		end

		// Master engine: leading edge drives master-out, trailing edge samples.
		case (sys_r.mstate)
			ssp_pkg::SSP_IDLE: begin
				sys_nxt.pins.sck = 1'b0;
				sys_nxt.cnt = '0;
				sys_nxt.div = ssp_pkg::SSP_SCK_HALF_CYC;
				if (tx_accept && is_master) begin
					sys_nxt.sh = i_tx_data;
					sys_nxt.pins.mosi = i_tx_data[7];
					sys_nxt.mstate = ssp_pkg::SSP_RUN;
				end
			end
			ssp_pkg::SSP_RUN: begin
				sys_nxt.div = sys_r.div - ssp_pkg::SSP_DIV_ONE;
				if (sck_tick) begin
					sys_nxt.div = ssp_pkg::SSP_SCK_HALF_CYC;
					sys_nxt.pins.sck = !sys_r.pins.sck;
					if (!sys_r.pins.sck) begin
						sys_nxt.pins.mosi = sys_r.sh[7];
					end else begin
						sys_nxt.sh = {sys_r.sh[6:0], miso_s};
						sys_nxt.cnt = sys_r.cnt + ssp_pkg::SSP_BIT_ONE;
						if (master_byte) begin
							sys_nxt.mstate = ssp_pkg::SSP_IDLE;
							sys_nxt.rx_data = {sys_r.sh[6:0], miso_s};
							sys_nxt.transfer_done_flag = 1'b1;
						end
					end
				end
				if (!is_master) begin
					sys_nxt.mstate = ssp_pkg::SSP_IDLE;
					sys_nxt.pins.sck = 1'b0;
				end
			end
			default: begin
				sys_nxt.mstate = ssp_pkg::SSP_IDLE;
			end
		endcase

		// A completed slave byte is kept only if the last one was taken.
		if (slave_byte) begin
			if (sys_r.transfer_done_flag && !i_done_clear) begin
				sys_nxt.overrun_flag = 1'b1;
			end else begin
				sys_nxt.rx_data = cap_r.rx_byte;
				sys_nxt.transfer_done_flag = 1'b1;
			end
		end

		// Another master pulled select low: give up the bus at once.
		if (four_slave_in && is_master && nss_fall) begin
			sys_nxt.cfg.master_enable_bit = 1'b0;
			sys_nxt.cfg.port_enable_bit = 1'b0;
			sys_nxt.mode_fault_flag = 1'b1;
			sys_nxt.mstate = ssp_pkg::SSP_IDLE;
			sys_nxt.pins.sck = 1'b0;
		end

		// Master-out and clock directions follow the next configuration so they change together.
		sys_nxt.pins.mosi_oe = sys_nxt.cfg.port_enable_bit
			&& sys_nxt.cfg.master_enable_bit;
		sys_nxt.pins.sck_oe = sys_nxt.pins.mosi_oe;
		sys_nxt.pins.miso_oe = is_slave && selected;
		sys_nxt.pins.nss_oe = select_out;
		sys_nxt.pins.nss = sys_r.cfg.select_mode_field[ssp_pkg::SSP_MODE_LEVEL_BIT];
		sys_nxt.pins.nss_mapped = !three_wire;

		// The link logic is held cleared whenever the slave is not selected,
		// so its bit counter restarts at every select falling edge. A 3-wire
		// slave only restarts when it leaves 3-wire slave mode (port disabled, master enabled or select mode field changed) and returns.
		sys_nxt.hold = !(is_slave && selected);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sys_r <= '0;
			sys_r.cfg.select_mode_field <= ssp_pkg::SSP_MODE_4W_SLAVE;
			sys_r.mstate <= ssp_pkg::SSP_IDLE;
			sys_r.div <= ssp_pkg::SSP_SCK_HALF_CYC;
			sys_r.hold <= 1'b1;
			sys_r.nss_prev <= 1'b1;
			sys_r.pins.nss_mapped <= 1'b1;
			sys_r.link_rst <= 1'b1;
		end else begin
			sys_r <= sys_nxt;
		end
	end

	// Slave link logic runs on the master's clock, which stands still between
	// bytes. Its clear comes from a system clock flip-flop, so release is clean
	// as long as select falls at least three system clocks before the first edge.
	always_comb begin
		lead_nxt = lead_r;
		if (lead_r.cnt == '0) begin
			lead_nxt.miso = sys_r.tx_buf[7];
			lead_nxt.tx_sh = {sys_r.tx_buf[6:0], 1'b0};
		end else begin
			lead_nxt.miso = lead_r.tx_sh[7];
			lead_nxt.tx_sh = {lead_r.tx_sh[6:0], 1'b0};
		end
		lead_nxt.cnt = lead_r.cnt + ssp_pkg::SSP_BIT_ONE;
	end

	always_comb begin
		trail_nxt = trail_r;
		cap_nxt = cap_r;
		trail_nxt.rx_sh = {trail_r.rx_sh[6:0], i_mosi};
		trail_nxt.cnt = trail_r.cnt + ssp_pkg::SSP_BIT_ONE;
		// The counter is held at zero while cleared, so no byte completes then.
		if (trail_r.cnt == ssp_pkg::SSP_LAST_BIT) begin
			cap_nxt.rx_byte = {trail_r.rx_sh[6:0], i_mosi};
			cap_nxt.tgl = !cap_r.tgl;
		end
	end

	always_ff @(posedge i_sck_link or posedge sys_r.hold) begin
		if (sys_r.hold) begin
			lead_r <= '0;
		end else begin
			lead_r <= lead_nxt;
		end
	end

	always_ff @(negedge i_sck_link or posedge sys_r.hold) begin
		if (sys_r.hold) begin
			trail_r <= '0;
		end else begin
			trail_r <= trail_nxt;
		end
	end

	// The toggle must survive a hold, or the system side would see a false byte.
	// Only the chip reset, passed on by a system flip-flop, clears it.
	always_ff @(negedge i_sck_link or posedge sys_r.link_rst) begin
		if (sys_r.link_rst) begin
			cap_r <= '0;
		end else begin
			cap_r <= cap_nxt;
		end
	end

	always_comb begin
		o_cfg = sys_r.cfg;
		o_transfer_done_flag = sys_r.transfer_done_flag;
		o_mode_fault_flag = sys_r.mode_fault_flag;
		o_overrun_flag = sys_r.overrun_flag;
		o_collision_flag = sys_r.collision_flag;
		o_busy = (sys_r.mstate == ssp_pkg::SSP_RUN);
		o_rx_data = sys_r.rx_data;
		o_pins = sys_r.pins;
		o_miso = lead_r.miso;
	end

endmodule : ssp_port

/* File: verilog/ssp_sync.sv */
`timescale 1ns/100ps

module ssp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ssp_sync_st_t;

	ssp_sync_st_t st_r;
	ssp_sync_st_t st_nxt;

	// The first stage is read only by the second stage.
	always_comb begin
		st_nxt.s1 = i_async;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			// Both stages start at the idle level of their line, so no false edge follows reset.
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_sync = st_r.s2;

endmodule : ssp_sync
